// >>> hdl/gvr_defines.svh
// Offsets, field positions, reset values and limits for the genset
// regulation control. Assumes inclusion by bare name from the design files.
`ifndef GVR_DEFINES_SVH
`define GVR_DEFINES_SVH

// Register indices on the plain register port (word addresses).
`define GVR_A_CTRL        8'h00
`define GVR_A_KNEE        8'h01
`define GVR_A_SLOPE       8'h02
`define GVR_A_AVR_K1      8'h03
`define GVR_A_AVR_K2      8'h04
`define GVR_A_AVR_K3      8'h05
`define GVR_A_AVR_K4      8'h06
`define GVR_A_GOV60_K1    8'h07
`define GVR_A_GOV60_K2    8'h08
`define GVR_A_GOV50_K1    8'h09
`define GVR_A_GOV50_K2    8'h0A
`define GVR_A_GOV_K3      8'h0B
`define GVR_A_GOV_K4      8'h0C
`define GVR_A_BOOT_THR    8'h0D
`define GVR_A_NOM_FREQ    8'h0E
`define GVR_A_STATUS      8'h0F
`define GVR_A_SETPOINT    8'h10
`define GVR_A_FIELD       8'h11
`define GVR_A_FUEL        8'h12
`define GVR_A_TABLE       8'h20

// Control register fields.
`define GVR_C_AVR_EN      0
`define GVR_C_HZ50        1
`define GVR_C_BS_LOADED   2
`define GVR_C_EXC_PMG     3
`define GVR_C_BS_SRC_LO   4
`define GVR_C_BS_SRC_HI   6

// Reset values (knee in 0.1 Hz, slope in 0.1 %V/Hz, gains as printed).
`define GVR_R_CTRL        16'h0001
`define GVR_R_KNEE        16'h0005
`define GVR_R_SLOPE       16'h0016
`define GVR_R_KNEE_MAX    16'h0064
`define GVR_R_SLOPE_MAX   16'h0032
`define GVR_R_AVR_K1      16'h03E8
`define GVR_R_AVR_K2      16'h028A
`define GVR_R_AVR_K3      16'h2710
`define GVR_R_AVR_K4      16'h8E4D
`define GVR_R_GOV60_K1    16'h06A0
`define GVR_R_GOV60_K2    16'h00F0
`define GVR_R_GOV50_K1    16'h04B0
`define GVR_R_GOV50_K2    16'h012C
`define GVR_R_GOV_K3      16'h7080
`define GVR_R_GOV_K4      16'h1D00
`define GVR_R_BOOT_THR    16'h0FA0
`define GVR_R_NOM_FREQ    16'h0258
`define GVR_R_FULL        16'h03E8
`define GVR_I_LIMIT       32'h0FFF_FFFF
`define GVR_TABLE_SHIFT   16'h0400

`endif

// >>> hdl/gvr_pkg.sv
// Types shared by the genset regulation control.
// Assumes nothing of its surroundings.
package gvr_pkg;

  typedef enum logic [3:0] {
    GVR_ST_WAIT  = 4'b0001,
    GVR_ST_BOOT  = 4'b0010,
    GVR_ST_LOOP  = 4'b0100,
    GVR_ST_OFF   = 4'b1000
  } gvr_state_t;

  // One four-coefficient gain set.
  typedef struct packed {
    logic [15:0] k1;
    logic [15:0] k2;
    logic [15:0] k3;
    logic [15:0] k4;
  } gvr_gains_t;

  // Sensed quantities, one sample per zero crossing.
  typedef struct packed {
    logic [15:0] freq;
    logic [15:0] volts;
    logic [15:0] speed;
  } gvr_sense_t;

endpackage

// >>> hdl/gvr_core.sv
// Genset regulation control: volts-per-hertz setpoint, regulator and governor
// loops run once per zero crossing, field startup stepping, battleshort.
// Assumes sensed values are steady in clk_sys; zero crossing and switches are pins.
//
// Our own choices: strobed register access and the register addresses.
`timescale 1ns/10ps
`include "gvr_defines.svh"

module gvr_core #(
  parameter int TABLE_DEPTH = 8
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic zero_cross,
  input wire gvr_pkg::gvr_sense_t sense,
  input wire logic [3:0] cfg_input,
  input wire logic panel_switch,
  input wire logic fault_shutdown,
  input wire logic fault_warning,
  output logic [15:0] field_pwm,
  output logic [15:0] fuel_cmd,
  output logic shutdown_out,
  output logic warning_out,
  output logic battleshort_active
);

  // ---------------------------------------------------------------------------
  // Local sizes
  // ---------------------------------------------------------------------------
  // Index widths follow the table depth, so a deeper table needs no edit below as long as its depth is a power of two.
  localparam int STEP_W = $clog2(TABLE_DEPTH);
  localparam int IDX_W = $clog2(2 * TABLE_DEPTH);
  // Both integrators stop at this bound; wrapping would flip the sign of the output.
  localparam logic signed [32:0] I_MAX = 33'(`GVR_I_LIMIT);

  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  logic [6:0] sync1_q;
  logic [6:0] sync2_q;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sync1_q <= 7'h00;
      sync2_q <= 7'h00;
    end else begin
      sync1_q <= {fault_warning, fault_shutdown, panel_switch, cfg_input};
      sync2_q <= sync1_q;
    end
  end
  // The zero crossing runs its own three-stage chain; the edge detector reads stages two and three.
  logic zc1_q;
  logic zc2_q;
  logic zc3_q;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      zc1_q <= 1'b0;
      zc2_q <= 1'b0;
      zc3_q <= 1'b0;
    end else begin
      zc1_q <= zero_cross;
      zc2_q <= zc1_q;
      zc3_q <= zc2_q;
    end
  end
  // One tick per rising zero crossing; the loops update on the edge after it.
  logic tick;
  assign tick = zc2_q & ~zc3_q;

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  logic [15:0] ctrl_q;
  logic [15:0] knee_q;
  logic [15:0] slope_q;
  gvr_pkg::gvr_gains_t avr_q;
  gvr_pkg::gvr_gains_t gov60_q;
  gvr_pkg::gvr_gains_t gov50_q;
  logic [15:0] boot_thr_q;
  logic [15:0] nom_freq_q;
  logic [15:0] table_q [2*TABLE_DEPTH];
  logic wr_ok;
  assign wr_ok = reg_wr;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ctrl_q <= `GVR_R_CTRL;
      knee_q <= `GVR_R_KNEE;
      slope_q <= `GVR_R_SLOPE;
      avr_q <= {`GVR_R_AVR_K1, `GVR_R_AVR_K2, `GVR_R_AVR_K3, `GVR_R_AVR_K4};
      gov60_q <= {`GVR_R_GOV60_K1, `GVR_R_GOV60_K2, `GVR_R_GOV_K3, `GVR_R_GOV_K4};
      gov50_q <= {`GVR_R_GOV50_K1, `GVR_R_GOV50_K2, `GVR_R_GOV_K3, `GVR_R_GOV_K4};
      boot_thr_q <= `GVR_R_BOOT_THR;
      nom_freq_q <= `GVR_R_NOM_FREQ;
    end else if (wr_ok) begin
      case (reg_addr)
        `GVR_A_CTRL: ctrl_q <= reg_wdata & 16'h007F;
        // Out-of-range settings clamp to the top of their range.
        `GVR_A_KNEE: knee_q <= (reg_wdata > `GVR_R_KNEE_MAX) ? `GVR_R_KNEE_MAX : reg_wdata;
        `GVR_A_SLOPE: slope_q <= (reg_wdata > `GVR_R_SLOPE_MAX) ? `GVR_R_SLOPE_MAX : reg_wdata;
        `GVR_A_AVR_K1: avr_q.k1 <= reg_wdata;
        `GVR_A_AVR_K2: avr_q.k2 <= reg_wdata;
        `GVR_A_AVR_K3: avr_q.k3 <= reg_wdata;
        `GVR_A_AVR_K4: avr_q.k4 <= reg_wdata;
        `GVR_A_GOV60_K1: gov60_q.k1 <= reg_wdata;
        `GVR_A_GOV60_K2: gov60_q.k2 <= reg_wdata;
        `GVR_A_GOV50_K1: gov50_q.k1 <= reg_wdata;
        `GVR_A_GOV50_K2: gov50_q.k2 <= reg_wdata;
        `GVR_A_GOV_K3: begin
          gov60_q.k3 <= reg_wdata;
          gov50_q.k3 <= reg_wdata;
        end
        `GVR_A_GOV_K4: begin
          gov60_q.k4 <= reg_wdata;
          gov50_q.k4 <= reg_wdata;
        end
        `GVR_A_BOOT_THR: boot_thr_q <= reg_wdata;
        `GVR_A_NOM_FREQ: nom_freq_q <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Two startup tables, shunt in the low half and PMG in the high half.
  genvar gi;
  generate
    for (gi = 0; gi < 2*TABLE_DEPTH; gi++) begin : g_tab
      always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
          table_q[gi] <= 16'((gi % TABLE_DEPTH + 1) * `GVR_TABLE_SHIFT);
        end else if (wr_ok && reg_addr == 8'(`GVR_A_TABLE + gi)) begin
          table_q[gi] <= reg_wdata;
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Battleshort
  // ---------------------------------------------------------------------------
  logic [2:0] bs_src;
  logic bs_switch;
  logic bs_on;
  assign bs_src = ctrl_q[`GVR_C_BS_SRC_HI:`GVR_C_BS_SRC_LO];
  // The chosen switch counts only once the feature is loaded.
  assign bs_on = ctrl_q[`GVR_C_BS_LOADED] & bs_switch;
  always_comb begin
    case (bs_src)
      3'h1: bs_switch = sync2_q[0];
      3'h2: bs_switch = sync2_q[1];
      3'h3: bs_switch = sync2_q[2];
      3'h4: bs_switch = sync2_q[3];
      3'h5: bs_switch = sync2_q[4];
      default: bs_switch = 1'b0;
    endcase
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      battleshort_active <= 1'b0;
      shutdown_out <= 1'b0;
      warning_out <= 1'b0;
    end else begin
      battleshort_active <= bs_on;
      shutdown_out <= sync2_q[5] & ~bs_on;
      warning_out <= sync2_q[6] & ~bs_on;
    end
  end

  // ---------------------------------------------------------------------------
  // Volts per hertz setpoint, in 0.1 % of rated
  // ---------------------------------------------------------------------------
  logic [15:0] short_f;
  logic [31:0] drop;
  logic [15:0] setpoint_d;
  logic [15:0] setpoint_q;
  always_comb begin
    // Shortfall of measured against commanded frequency, both in 0.1 Hz.
    short_f = (sense.freq < nom_freq_q) ? 16'(nom_freq_q - sense.freq) : 16'h0000;
    drop = 32'h0000_0000;
    if (short_f > knee_q) begin
      // The same pair serves either line frequency.
      drop = 32'((short_f - knee_q) * slope_q) / 32'h0000_000A;
    end
    // A drop at or past full scale pins the setpoint to zero rather than wrapping.
    setpoint_d = (drop >= 32'(`GVR_R_FULL)) ? 16'h0000 : 16'(32'(`GVR_R_FULL) - drop);
  end

  // ---------------------------------------------------------------------------
  // Loops and startup sequence
  // ---------------------------------------------------------------------------
  gvr_pkg::gvr_state_t state_q;
  logic [STEP_W-1:0] step_q;
  logic signed [31:0] avr_int_q;
  logic signed [31:0] gov_int_q;
  logic signed [17:0] avr_err_prev_q;
  logic signed [17:0] gov_err_prev_q;
  logic signed [17:0] avr_err;
  logic signed [17:0] gov_err;
  logic signed [31:0] avr_int_d;
  logic signed [31:0] gov_int_d;
  logic signed [63:0] avr_sum;
  logic signed [63:0] gov_sum;
  gvr_pkg::gvr_gains_t gov_sel;

  assign gov_sel = ctrl_q[`GVR_C_HZ50] ? gov50_q : gov60_q;

  function automatic logic signed [31:0] sat_add(input logic signed [31:0] a, input logic signed [17:0] e);
    logic signed [32:0] s;
    s = 33'(a) + 33'(e);
    if (s > I_MAX) begin
      sat_add = I_MAX[31:0];
    end else if (s < -I_MAX) begin
      sat_add = 32'(-I_MAX);
    end else begin
      sat_add = s[31:0];
    end
  endfunction

  always_comb begin
    avr_err = 18'(signed'({2'b00, setpoint_q})) - 18'(signed'({2'b00, sense.volts}));
    gov_err = 18'(signed'({2'b00, nom_freq_q})) - 18'(signed'({2'b00, sense.freq}));
    avr_int_d = sat_add(avr_int_q, avr_err);
    gov_int_d = sat_add(gov_int_q, gov_err);
    // P + I*sum + K3*delta; K4 is not used, output scaling is a fixed shift.
    avr_sum = 64'(signed'({1'b0, avr_q.k1})) * 64'(avr_err) + 64'(signed'({1'b0, avr_q.k2})) * 64'(avr_int_d)
            + 64'(signed'({1'b0, avr_q.k3})) * 64'(avr_err - avr_err_prev_q);
    gov_sum = 64'(signed'({1'b0, gov_sel.k1})) * 64'(gov_err) + 64'(signed'({1'b0, gov_sel.k2})) * 64'(gov_int_d)
            + 64'(signed'({1'b0, gov_sel.k3})) * 64'(gov_err - gov_err_prev_q);
  end

  function automatic logic [15:0] clip(input logic signed [63:0] v);
    if (v < 0) begin
      clip = 16'h0000;
    end else if (v > 64'sh0000_0000_FFFF_0000) begin
      clip = 16'hFFFF;
    end else begin
      clip = v[31:16];
    end
  endfunction

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      setpoint_q <= `GVR_R_FULL;
    end else if (tick) begin
      setpoint_q <= setpoint_d;
    end
  end

  // The governor runs from reset on; it does not wait for the startup sequence.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      gov_int_q <= 32'sh0000_0000;
      gov_err_prev_q <= 18'sh0_0000;
      fuel_cmd <= 16'h0000;
    end else if (tick) begin
      gov_int_q <= gov_int_d;
      gov_err_prev_q <= gov_err;
      fuel_cmd <= clip(gov_sum);
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_q <= gvr_pkg::GVR_ST_WAIT;
      step_q <= '0;
      avr_int_q <= 32'sh0000_0000;
      avr_err_prev_q <= 18'sh0_0000;
      field_pwm <= 16'h0000;
    end else if (!ctrl_q[`GVR_C_AVR_EN]) begin
      // Disabling drops the field at once and clears the integrator, so a later
      // enable restarts from the startup table instead of from stale windup.
      state_q <= gvr_pkg::GVR_ST_OFF;
      field_pwm <= 16'h0000;
      avr_int_q <= 32'sh0000_0000;
    end else if (tick) begin
      case (state_q)
        gvr_pkg::GVR_ST_OFF, gvr_pkg::GVR_ST_WAIT: begin
          field_pwm <= 16'h0000;
          step_q <= '0;
          if (sense.speed >= nom_freq_q) begin
            state_q <= gvr_pkg::GVR_ST_BOOT;
          end else begin
            state_q <= gvr_pkg::GVR_ST_WAIT;
          end
        end
        gvr_pkg::GVR_ST_BOOT: begin
          if (sense.volts > boot_thr_q) begin
            state_q <= gvr_pkg::GVR_ST_LOOP;
            avr_int_q <= 32'sh0000_0000;
          end else begin
            field_pwm <= table_q[{ctrl_q[`GVR_C_EXC_PMG], step_q}];
            if (step_q != STEP_W'(TABLE_DEPTH - 1)) begin
              step_q <= step_q + 1'b1;
            end
          end
        end
        gvr_pkg::GVR_ST_LOOP: begin
          avr_int_q <= avr_int_d;
          avr_err_prev_q <= avr_err;
          field_pwm <= clip(avr_sum);
        end
        default: state_q <= gvr_pkg::GVR_ST_WAIT;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------------------
  // Reads are registered; the value stays until the next read strobe.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `GVR_A_CTRL: reg_rdata <= ctrl_q;
        `GVR_A_KNEE: reg_rdata <= knee_q;
        `GVR_A_SLOPE: reg_rdata <= slope_q;
        `GVR_A_AVR_K1: reg_rdata <= avr_q.k1;
        `GVR_A_AVR_K2: reg_rdata <= avr_q.k2;
        `GVR_A_AVR_K3: reg_rdata <= avr_q.k3;
        `GVR_A_AVR_K4: reg_rdata <= avr_q.k4;
        `GVR_A_GOV60_K1: reg_rdata <= gov60_q.k1;
        `GVR_A_GOV60_K2: reg_rdata <= gov60_q.k2;
        `GVR_A_GOV50_K1: reg_rdata <= gov50_q.k1;
        `GVR_A_GOV50_K2: reg_rdata <= gov50_q.k2;
        `GVR_A_GOV_K3: reg_rdata <= gov60_q.k3;
        `GVR_A_GOV_K4: reg_rdata <= gov60_q.k4;
        `GVR_A_BOOT_THR: reg_rdata <= boot_thr_q;
        `GVR_A_NOM_FREQ: reg_rdata <= nom_freq_q;
        `GVR_A_STATUS: reg_rdata <= {11'h000, battleshort_active, state_q};
        `GVR_A_SETPOINT: reg_rdata <= setpoint_q;
        `GVR_A_FIELD: reg_rdata <= field_pwm;
        `GVR_A_FUEL: reg_rdata <= fuel_cmd;
        default: begin
          if (reg_addr >= `GVR_A_TABLE && reg_addr < 8'(`GVR_A_TABLE + 2*TABLE_DEPTH)) begin
            reg_rdata <= table_q[IDX_W'(reg_addr - `GVR_A_TABLE)];
          end else begin
            reg_rdata <= 16'h0000;
          end
        end
      endcase
    end
  end

endmodule

// >>> sim/gvr_core_properties.sv
// Concurrent checks for the genset regulation control, bound onto its ports.
// Assumes one clock clk_sys and the asynchronous active-low reset nrst.
`timescale 1ns/10ps
module gvr_core_properties #(
  parameter int TABLE_DEPTH = 8
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic zero_cross,
  input wire logic fault_shutdown,
  input wire logic fault_warning,
  input wire logic [15:0] field_pwm,
  input wire logic [15:0] fuel_cmd,
  input wire logic shutdown_out,
  input wire logic warning_out,
  input wire logic battleshort_active
);
  // ----------------------------------------------------------------
  // Zero-crossing history
  // ----------------------------------------------------------------
  // Eight samples cover the pin synchroniser plus the update edge.
  logic [7:0] zc_hist_q;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      zc_hist_q <= 8'h00;
    end else begin
      zc_hist_q <= {zc_hist_q[6:0], zero_cross};
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_fuel_on_tick;
    $changed(fuel_cmd) |-> (zc_hist_q != 8'h00);
  endproperty
  a_fuel_on_tick: assert property (p_fuel_on_tick) else $error("fuel moved off a tick");
  property p_field_on_tick;
    ($changed(field_pwm) && field_pwm != 16'h0000) |-> (zc_hist_q != 8'h00);
  endproperty
  a_field_on_tick: assert property (p_field_on_tick) else $error("field moved off a tick");
  property p_bs_masks;
    battleshort_active [*3] |-> (!shutdown_out && !warning_out);
  endproperty
  a_bs_masks: assert property (p_bs_masks) else $error("fault passed in battleshort");
  property p_shut_pass;
    (!battleshort_active && $stable(fault_shutdown)) [*5] |-> shutdown_out == fault_shutdown;
  endproperty
  a_shut_pass: assert property (p_shut_pass) else $error("shutdown not passed");
  property p_warn_pass;
    (!battleshort_active && $stable(fault_warning)) [*5] |-> warning_out == fault_warning;
  endproperty
  a_warn_pass: assert property (p_warn_pass) else $error("warning not passed");
  property p_avr_off;
    (reg_wr && reg_addr == 8'h00 && !reg_wdata[0]) |-> ##[1:3] field_pwm == 16'h0000;
  endproperty
  a_avr_off: assert property (p_avr_off) else $error("field alive with regulation off");
  property p_knee_clamp;
    (reg_wr && reg_addr == 8'h01 && reg_wdata > 16'h0064) ##2 (reg_rd && reg_addr == 8'h01)
      |=> reg_rdata == 16'h0064;
  endproperty
  a_knee_clamp: assert property (p_knee_clamp) else $error("knee not clamped");
  property p_slope_clamp;
    (reg_wr && reg_addr == 8'h02 && reg_wdata > 16'h0032) ##2 (reg_rd && reg_addr == 8'h02)
      |=> reg_rdata == 16'h0032;
  endproperty
  a_slope_clamp: assert property (p_slope_clamp) else $error("slope not clamped");
  property p_rdata_hold;
    !$past(reg_rd) |-> $stable(reg_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without a read");
endmodule
bind gvr_core gvr_core_properties #(.TABLE_DEPTH(TABLE_DEPTH)) u_props (
  .clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .zero_cross(zero_cross), .fault_shutdown(fault_shutdown),
  .fault_warning(fault_warning), .field_pwm(field_pwm), .fuel_cmd(fuel_cmd), .shutdown_out(shutdown_out),
  .warning_out(warning_out), .battleshort_active(battleshort_active)
);

// >>> sim/gvr_plant.sv
// Generator model: zero-crossing pulses, frequency and speed from the bench,
// terminal voltage that lags the field command. Assumes clk_sys at 10 MHz.
`timescale 1ns/10ps
module gvr_plant #(
  parameter int PERIOD = 40
) (
  input wire logic clk_sys,
  input wire logic [15:0] speed_set,
  input wire logic [15:0] field_pwm,
  output logic zero_cross,
  output gvr_pkg::gvr_sense_t sense
);
  // ----------------------------------------------------------------
  // Waveform and voltage
  // ----------------------------------------------------------------
  int cnt = 0;
  logic [15:0] volts_q = 16'h0000;
  always_ff @(posedge clk_sys) begin
    cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
  end
  assign zero_cross = (cnt < 4);
  // Voltage moves mid-cycle so the sensed values are steady at each tick.
  always_ff @(posedge clk_sys) begin
    if (cnt == PERIOD / 2) begin
      volts_q <= 16'((int'(volts_q) * 3 + int'(field_pwm >> 3)) / 4);
    end
  end
  assign sense = '{freq: speed_set, volts: volts_q, speed: speed_set};
endmodule

// >>> sim/test_genset_volts_hz_regulation_control.sv
// Self-checking bench for the genset regulation control.
// Assumes the generator model and the bound checker are compiled before it.
`timescale 1ns/10ps
module test_genset_volts_hz_regulation_control;
  logic clk_sys, nrst, reg_wr, reg_rd, zero_cross, panel_switch, fault_shutdown, fault_warning;
  logic shutdown_out, warning_out, battleshort_active, done;
  logic [7:0] reg_addr;
  logic [3:0] cfg_input, c;
  logic [15:0] reg_wdata, reg_rdata, field_pwm, fuel_cmd, speed_set, v, prev;
  gvr_pkg::gvr_sense_t sense;
  int failures = 0;
  int check_count = 0;
  int cycles = 0;
  logic [7:0] ra [16] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A,
    8'h0B, 8'h0C, 8'h0E, 8'h20, 8'h13};
  logic [15:0] rv [16] = '{16'h0001, 16'h0005, 16'h0016, 16'h03E8, 16'h028A, 16'h2710, 16'h8E4D,
    16'h06A0, 16'h00F0, 16'h04B0, 16'h012C, 16'h7080, 16'h1D00, 16'h0258, 16'h0400, 16'h0000};
  gvr_core #(.TABLE_DEPTH(8)) u_dut (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .zero_cross(zero_cross), .sense(sense), .cfg_input(cfg_input), .panel_switch(panel_switch),
    .fault_shutdown(fault_shutdown), .fault_warning(fault_warning), .field_pwm(field_pwm),
    .fuel_cmd(fuel_cmd), .shutdown_out(shutdown_out), .warning_out(warning_out),
    .battleshort_active(battleshort_active));
  gvr_plant #(.PERIOD(40)) u_plant (.clk_sys(clk_sys), .speed_set(speed_set), .field_pwm(field_pwm),
    .zero_cross(zero_cross), .sense(sense));
  // ----------------------------------------------------------------
  // Clock, timeout and shared tasks
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // The whole run needs roughly 3300 cycles; the ceiling leaves ample room.
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      conclude();
    end
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
    rd(a, v);
    chk(v, exp);
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge zero_cross);
      repeat (6) @(posedge clk_sys);
    end
  endtask
  function automatic int sp_model(int f, int knee, int slope, int nom);
    return (nom - f > knee) ? 1000 - slope * (nom - f - knee) / 10 : 1000;
  endfunction
  task automatic spchk(input int f, input int knee, input int slope, input int nom);
    wr(8'h01, 16'(knee));
    wr(8'h02, 16'(slope));
    @(posedge clk_sys);
    speed_set <= 16'(f);
    ticks(2);
    rdchk(8'h10, 16'(sp_model(f, knee, slope, nom)));
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    cfg_input = 4'h0;
    panel_switch = 1'b0;
    fault_shutdown = 1'b0;
    fault_warning = 1'b0;
    speed_set = 16'h01F4;
    void'($urandom(32'hE2F2));
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
    for (int i = 0; i < 16; i++) rdchk(ra[i], rv[i]);
    $display("reset values done");
    ticks(3);
    chk(field_pwm, 16'h0000);
    rdchk(8'h0F, {12'h000, gvr_pkg::GVR_ST_WAIT});
    prev = 16'(200 + $urandom % 1301);
    wr(8'h04, prev);
    rdchk(8'h04, prev);
    wr(8'h0D, 16'h01F4);
    @(posedge clk_sys);
    speed_set <= 16'h0258;
    ticks(2);
    done = 1'b0;
    for (int i = 0; i < 30 && !done; i++) begin
      rd(8'h0F, v);
      if (v[3:0] === gvr_pkg::GVR_ST_LOOP) done = 1'b1;
      else chk({15'h0000, field_pwm != 16'h0000 && field_pwm[9:0] == 10'h000}, 16'h0001);
      ticks(1);
    end
    chk({15'h0000, done}, 16'h0001);
    $display("startup done");
    wr(8'h00, 16'h0000);
    repeat (3) @(posedge clk_sys);
    chk(field_pwm, 16'h0000);
    rdchk(8'h0F, {12'h000, gvr_pkg::GVR_ST_OFF});
    ticks(12);
    chk(field_pwm, 16'h0000);
    for (int i = 0; i < 8; i++) wr(8'h28 + 8'(i), 16'h0123);
    wr(8'h0D, 16'h03E8);
    wr(8'h00, 16'h0009);
    ticks(4);
    chk(field_pwm, 16'h0123);
    $display("source table done");
    @(posedge clk_sys);
    speed_set <= 16'h01F4;
    ticks(2);
    prev = fuel_cmd;
    v = fuel_cmd;
    for (int i = 0; i < 20; i++) begin
      ticks(1);
      chk({15'h0000, fuel_cmd >= prev}, 16'h0001);
      prev = fuel_cmd;
    end
    chk({15'h0000, fuel_cmd > v}, 16'h0001);
    $display("governor done");
    @(posedge clk_sys);
    fault_shutdown <= 1'b1;
    fault_warning <= 1'b1;
    for (int s = 0; s < 7; s++) begin
      for (int b = 0; b < 2; b++) begin
        wr(8'h00, 16'h0009 | 16'((s < 6 ? s : 1) << 4) | 16'((s < 6) << 2));
        c = 4'hF;
        if (s >= 1 && s <= 4) c[s - 1] = b[0];
        @(posedge clk_sys);
        cfg_input <= c;
        panel_switch <= (s == 5) ? b[0] : 1'b1;
        repeat (6) @(posedge clk_sys);
        #1 chk({15'h0000, battleshort_active}, {15'h0000, s >= 1 && s <= 5 && b == 1});
        chk({14'h0000, shutdown_out, warning_out}, (s >= 1 && s <= 5 && b == 1) ? 16'h0000 : 16'h0003);
      end
    end
    @(posedge clk_sys);
    fault_shutdown <= 1'b0;
    cfg_input <= 4'h0;
    $display("battleshort done");
    wr(8'h01, 16'h0065);
    rdchk(8'h01, 16'h0064);
    wr(8'h02, 16'h0033);
    rdchk(8'h02, 16'h0032);
    wr(8'h02, 16'h0001);
    rdchk(8'h02, 16'h0001);
    $display("range limits done");
    spchk(565, 5, 22, 600);
    spchk(620, 5, 22, 600);
    spchk(600, 0, 50, 600);
    for (int i = 0; i < 8; i++) spchk(500 + $urandom % 121, $urandom % 101, $urandom % 51, 600);
    wr(8'h0E, 16'h01F4);
    wr(8'h00, 16'h000B);
    spchk(465, 5, 22, 500);
    $display("setpoint done");
    conclude();
  end
endmodule
